// file: pkg/ncp_cfg.svh
/*
 * numeric coprocessor port constants: port addresses, fault vector, rest levels.
 * assumes: included by bare name from design and bench files.
 */
`ifndef NCP_CFG_SVH
`define NCP_CFG_SVH

// ----------------------------------------------------------------------
// port addresses in i/o space
// ----------------------------------------------------------------------
`define NCP_ADDR_OPCODE 24'h8000f8
`define NCP_ADDR_OPERAND 24'h8000fc
`define NCP_ADDR_OPERAND_HI 24'h8000fe
`define NCP_PIO_TOP 24'h00ffff

// ----------------------------------------------------------------------
// fault vector, pin rest levels, half width and sync latency
// ----------------------------------------------------------------------
`define NCP_FAULT_VEC 8'h10
`define NCP_BUSY_REST 1'b1
`define NCP_ERR_REST 1'b1
`define NCP_REQ_REST 1'b0
`define NCP_HALF_W 16
`define NCP_SYNC_LAT 2

`endif

// file: pkg/ncp_pkg.sv
/*
 * types of the numeric coprocessor port.
 * assumes: nothing beyond the constants header.
 */
package ncp_pkg;
    // sequencer of the processor side
    typedef enum logic [2:0] {
        ST_IDLE, ST_CHECK, ST_OPCODE, ST_OPERAND, ST_WAIT
    } ncp_state_t;
    // bus cycle engine
    typedef enum logic [1:0] {
        EN_IDLE, EN_FIRST, EN_SECOND
    } ncp_eng_t;
    // which coprocessor register a transfer targets
    typedef enum logic {
        KIND_OPCODE, KIND_OPERAND
    } ncp_kind_t;
endpackage : ncp_pkg

// file: pkg/ncp_xfer_if.sv
/*
 * carrier between the sequencer and the bus cycle engine.
 * assumes: both ends on sys_clk.
 */
`timescale 1ns/1ps
interface ncp_xfer_if;
    import ncp_pkg::*;
    logic start; // one-cycle launch
    ncp_kind_t kind; // opcode or operand register
    logic dword; // operand split into two half cycles
    logic rd; // operand read from the partner
    logic [31:0] wdata; // data to send
    logic busy; // engine occupied
    logic done; // one-cycle end of transfer
    logic [31:0] rdata; // data read back
    modport ctl (output start, kind, dword, rd, wdata, input busy, done, rdata);
    modport eng (input start, kind, dword, rd, wdata, output busy, done, rdata);
endinterface : ncp_xfer_if

// file: hdl/ncp_xfer.sv
/*
 * bus cycle engine: turns one transfer into one or two i/o bus cycles.
 * assumes: bus unit acks each cycle with io_ack on sys_clk.
 */
`timescale 1ns/1ps
`include "ncp_cfg.svh"
module ncp_xfer import ncp_pkg::*; #(
    parameter int ADDR_W = 24
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // sequencer side
    ncp_xfer_if.eng xf,
    // i/o bus
    output logic io_req,
    output logic [ADDR_W-1:0] io_addr,
    output logic io_wr,
    output logic [`NCP_HALF_W-1:0] io_wdata,
    input wire logic [`NCP_HALF_W-1:0] io_rdata,
    input wire logic io_ack
);
    ncp_eng_t st_ff; // engine state
    logic dword_ff; // second half pending
    logic [`NCP_HALF_W-1:0] hi_ff; // upper half to send
    logic done_ff; // end pulse
    logic [31:0] rdata_ff; // assembled read data

    assign xf.busy = (st_ff != EN_IDLE);
    assign xf.done = done_ff;
    assign xf.rdata = rdata_ff;

    // ------------------------------------------------------------------
    // cycle issue: request held until acked
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= EN_IDLE;
            io_req <= 1'b0;
            io_addr <= '0;
            io_wr <= 1'b0;
            io_wdata <= '0;
            dword_ff <= 1'b0;
            hi_ff <= '0;
            done_ff <= 1'b0;
            rdata_ff <= '0;
        end else if (clk_en) begin
            done_ff <= 1'b0;
            unique case (st_ff)
                EN_IDLE: begin
                    if (xf.start) begin
                        st_ff <= EN_FIRST;
                        io_req <= 1'b1;
                        io_wr <= !(xf.rd && xf.kind == KIND_OPERAND); // opcode: write
                        io_wdata <= xf.wdata[15:0];
                        hi_ff <= xf.wdata[31:16];
                        dword_ff <= xf.dword && (xf.kind == KIND_OPERAND);
                        // fixed port per register
                        io_addr <= (xf.kind == KIND_OPCODE) ?
                            ADDR_W'(`NCP_ADDR_OPCODE) : ADDR_W'(`NCP_ADDR_OPERAND);
                    end
                end
                EN_FIRST: begin
                    if (io_ack) begin
                        rdata_ff <= {16'h0000, io_rdata};
                        if (dword_ff) begin
                            // upper half goes out as its own cycle
                            st_ff <= EN_SECOND;
                            io_addr <= ADDR_W'(`NCP_ADDR_OPERAND_HI);
                            io_wdata <= hi_ff;
                        end else begin
                            st_ff <= EN_IDLE;
                            io_req <= 1'b0;
                            done_ff <= 1'b1;
                        end
                    end
                end
                EN_SECOND: begin
                    if (io_ack) begin
                        rdata_ff[31:16] <= io_rdata;
                        st_ff <= EN_IDLE;
                        io_req <= 1'b0;
                        done_ff <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    opc_port_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && st_ff == EN_IDLE && xf.start && xf.kind == KIND_OPCODE
        |=> io_req && io_addr == ADDR_W'(`NCP_ADDR_OPCODE))
        else $error("opcode cycle not at opcode port");
    dword_second_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && st_ff == EN_FIRST && io_ack && dword_ff
        |=> io_req && io_addr == ADDR_W'(`NCP_ADDR_OPERAND_HI))
        else $error("second dword cycle misaddressed");
    io_range_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        io_req |-> io_addr > ADDR_W'(`NCP_PIO_TOP))
        else $error("coprocessor cycle inside programmed i/o range");
endmodule : ncp_xfer

// file: hdl/ncp_port.sv
/*
 * numeric coprocessor port, processor side: pin sync, busy/error gating,
 * opcode and operand bus cycles, error fault.
 * assumes: core side and bus ack on sys_clk; coprocessor pins asynchronous.
 */
`timescale 1ns/1ps
`include "ncp_cfg.svh"
module ncp_port import ncp_pkg::*; #(
    parameter int ADDR_W = 24
) (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clk_en,
    // core instruction side
    input wire logic cop_start,
    input wire logic [15:0] cop_opcode,
    input wire logic cop_has_operand,
    input wire logic cop_dword,
    input wire logic cop_rd,
    input wire logic [31:0] cop_operand,
    input wire logic wait_start,
    input wire logic nmi_pending,
    input wire logic irq_pending,
    // core status side
    output logic core_stall,
    output logic cop_done,
    output logic [31:0] cop_rdata,
    output logic fault_pulse,
    output logic [7:0] fault_vector,
    output logic wait_broken,
    output logic selftest_req,
    // coprocessor pins
    input wire logic busy_n,
    input wire logic error_n,
    input wire logic operand_xfer_request,
    // i/o bus
    output logic io_req,
    output logic [ADDR_W-1:0] io_addr,
    output logic io_wr,
    output logic [15:0] io_wdata,
    input wire logic [15:0] io_rdata,
    input wire logic io_ack
);
    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    logic rst_meta_ff; // first stage of reset release
    logic rst_n; // released reset used by all logic

    // two flops so that release never lands mid-cycle on the design
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_ff <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n <= rst_meta_ff;
        end
    end

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic busy_meta_ff, err_meta_ff, req_meta_ff; // first stages, read only by second
    logic busy_n_ff, error_n_ff, req_ff; // usable copies
    logic busy; // partner busy, active high
    logic err; // partner error, active high

    // rest levels match the pin pulls, so a missing partner reads idle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_meta_ff <= `NCP_BUSY_REST;
            busy_n_ff <= `NCP_BUSY_REST;
            err_meta_ff <= `NCP_ERR_REST;
            error_n_ff <= `NCP_ERR_REST;
            req_meta_ff <= `NCP_REQ_REST;
            req_ff <= `NCP_REQ_REST;
        end else if (clk_en) begin
            busy_meta_ff <= busy_n;
            busy_n_ff <= busy_meta_ff;
            err_meta_ff <= error_n;
            error_n_ff <= err_meta_ff;
            req_meta_ff <= operand_xfer_request;
            req_ff <= req_meta_ff;
        end
    end
    assign busy = !busy_n_ff;
    assign err = !error_n_ff;

    // ------------------------------------------------------------------
    // self-test request caught once after release
    // ------------------------------------------------------------------
    logic [1:0] strap_cnt_ff; // edges since release

    // wait until both sync stages carry the pin, not their rest level
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_cnt_ff <= '0;
            selftest_req <= 1'b0;
        end else if (clk_en && strap_cnt_ff != 2'(`NCP_SYNC_LAT + 1)) begin
            strap_cnt_ff <= strap_cnt_ff + 2'h1;
            if (strap_cnt_ff == 2'(`NCP_SYNC_LAT)) begin
                selftest_req <= busy;
            end
        end
    end

    // ------------------------------------------------------------------
    // bus cycle engine
    // ------------------------------------------------------------------
    ncp_xfer_if xf ();
    logic start_ff; // launch pulse
    ncp_kind_t kind_ff; // register targeted
    logic [31:0] wdata_ff; // data to send
    logic dword_ff; // operand is a doubleword
    logic rd_ff; // operand read

    assign xf.start = start_ff;
    assign xf.kind = kind_ff;
    assign xf.dword = dword_ff;
    assign xf.rd = rd_ff;
    assign xf.wdata = wdata_ff;

    ncp_xfer #(.ADDR_W(ADDR_W)) u_xfer (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .xf(xf),
        .io_req(io_req),
        .io_addr(io_addr),
        .io_wr(io_wr),
        .io_wdata(io_wdata),
        .io_rdata(io_rdata),
        .io_ack(io_ack)
    );

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    ncp_state_t st_ff; // sequencer state
    logic served_ff; // at least one operand cycle ran, or the instruction has no operand
    logic brk; // interrupt able to break a wait

    assign brk = nmi_pending || irq_pending;

    // one process owns the state and every core-facing flag except selftest_req
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= ST_IDLE;
            start_ff <= 1'b0;
            kind_ff <= KIND_OPCODE;
            wdata_ff <= '0;
            dword_ff <= 1'b0;
            rd_ff <= 1'b0;
            served_ff <= 1'b0;
            core_stall <= 1'b0;
            cop_done <= 1'b0;
            cop_rdata <= '0;
            fault_pulse <= 1'b0;
            fault_vector <= '0;
            wait_broken <= 1'b0;
        end else if (clk_en) begin
            start_ff <= 1'b0;
            cop_done <= 1'b0;
            fault_pulse <= 1'b0;
            wait_broken <= 1'b0;
            unique case (st_ff)
                ST_IDLE: begin
                    served_ff <= 1'b0;
                    if (cop_start) begin
                        // hold instruction details for the whole sequence
                        st_ff <= ST_CHECK;
                        core_stall <= 1'b1;
                        wdata_ff <= {16'h0000, cop_opcode};
                        dword_ff <= cop_dword;
                        rd_ff <= cop_rd;
                        served_ff <= !cop_has_operand;
                    end else if (wait_start) begin
                        st_ff <= ST_WAIT;
                        core_stall <= 1'b1;
                    end
                end
                ST_CHECK: begin
                    // partner must be free before anything goes out
                    if (!busy) begin
                        if (err) begin
                            st_ff <= ST_IDLE;
                            core_stall <= 1'b0;
                            fault_pulse <= 1'b1;
                            fault_vector <= `NCP_FAULT_VEC;
                        end else begin
                            // opcode goes straight out, no preamble
                            st_ff <= ST_OPCODE;
                            start_ff <= 1'b1;
                            kind_ff <= KIND_OPCODE;
                        end
                    end
                end
                ST_OPCODE: begin
                    if (xf.done) begin
                        st_ff <= ST_OPERAND;
                        kind_ff <= KIND_OPERAND;
                        wdata_ff <= cop_operand;
                    end
                end
                ST_OPERAND: begin
                    // operand cycles follow the partner's request; on an instruction with an
                    // operand, a partner that never asks keeps the core stalled
                    if (xf.done) begin
                        served_ff <= 1'b1;
                        cop_rdata <= xf.rdata;
                    end else if (!xf.busy && !start_ff) begin
                        if (req_ff) begin
                            start_ff <= 1'b1;
                        end else if (served_ff) begin
                            st_ff <= ST_IDLE;
                            core_stall <= 1'b0;
                            cop_done <= 1'b1;
                        end
                    end
                end
                ST_WAIT: begin
                    if (!busy) begin
                        // error seen as busy ends turns into the fault
                        st_ff <= ST_IDLE;
                        core_stall <= 1'b0;
                        if (err) begin
                            fault_pulse <= 1'b1;
                            fault_vector <= `NCP_FAULT_VEC;
                        end else begin
                            cop_done <= 1'b1;
                        end
                    end else if (brk) begin
                        // interrupt wins while still busy; the wait restarts after service
                        st_ff <= ST_IDLE;
                        core_stall <= 1'b0;
                        wait_broken <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    busy_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && st_ff == ST_CHECK && busy |=> st_ff == ST_CHECK && !start_ff)
        else $error("instruction passed a busy partner");
    opcode_direct_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && st_ff == ST_CHECK && !busy && !err
        |=> start_ff && kind_ff == KIND_OPCODE ##1 io_req)
        else $error("opcode not issued at once");
    wait_stall_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && st_ff == ST_WAIT && busy && !brk |=> core_stall && st_ff == ST_WAIT)
        else $error("wait released while busy");
    wait_break_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && st_ff == ST_WAIT && busy && brk |=> wait_broken && !core_stall)
        else $error("interrupt did not break wait");
    wait_fault_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && st_ff == ST_WAIT && !busy && err
        |=> fault_pulse && fault_vector == `NCP_FAULT_VEC && !cop_done)
        else $error("error at wait end gave no fault 16");
    operand_serve_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && st_ff == ST_OPERAND && req_ff && !xf.busy && !xf.done && !start_ff
        |=> start_ff ##1 io_req && io_addr == ADDR_W'(`NCP_ADDR_OPERAND))
        else $error("operand request not served");
endmodule : ncp_port

// file: sim/ncp_cop_model.sv
/*
 * partner model: coprocessor pins and the i/o bus answer.
 * assumes: bench sets busy, error and operand demand; sys_clk only.
 */
`timescale 1ns/1ps
module ncp_cop_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // bench controls
    input wire logic busy_on,
    input wire logic err_on,
    input wire logic selftest,
    input wire logic [1:0] ack_dly,
    input wire logic [1:0] ops,
    // coprocessor pins
    output logic busy_n,
    output logic error_n,
    output logic operand_xfer_request,
    // i/o bus
    input wire logic io_req,
    input wire logic [23:0] io_addr,
    input wire logic io_wr,
    input wire logic [15:0] io_wdata,
    output logic [15:0] io_rdata,
    output logic io_ack
);
    // ------------------------------------------------------------------
    // decode and transfer log
    // ------------------------------------------------------------------
    wire sel_lo = io_addr[2];
    wire sel_hi = 1'b0;
    logic [1:0] wait_cnt_ff; // ack delay count
    logic [1:0] ops_left_ff; // operand transfers still wanted
    int n_log; // entries logged so far
    logic [23:0] log_addr [32];
    logic [15:0] log_dat [32];
    logic log_wr [32];
    logic log_sel [32];
    // first low operand port cycle meets one demand
    wire take = io_req && !io_ack && sel_lo && !sel_hi && !io_addr[1] && wait_cnt_ff == 2'h0;

    // ------------------------------------------------------------------
    // pins and bus answer
    // ------------------------------------------------------------------
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            busy_n <= !selftest;
            error_n <= 1'b1;
            operand_xfer_request <= 1'b0;
            io_ack <= 1'b0;
            io_rdata <= 16'h0;
            wait_cnt_ff <= 2'h0;
            ops_left_ff <= 2'h0;
            n_log <= 0;
        end else begin
            busy_n <= !(busy_on || selftest);
            error_n <= !err_on;
            io_ack <= 1'b0;
            // an idle bus inverts every bit each cycle, so the last word shows every other cycle
            io_rdata <= ~io_rdata;
            // demand drops as soon as its transfer begins
            operand_xfer_request <= ops_left_ff != 2'h0 && !take;
            if (take && ops_left_ff != 2'h0) begin
                ops_left_ff <= ops_left_ff - 2'h1;
            end
            if (io_req && !io_ack) begin
                if (wait_cnt_ff < ack_dly) begin
                    wait_cnt_ff <= wait_cnt_ff + 2'h1;
                end else begin
                    wait_cnt_ff <= 2'h0;
                    io_ack <= 1'b1;
                    io_rdata <= {8'ha5, io_addr[7:0]};
                    log_addr[n_log] <= io_addr;
                    log_dat[n_log] <= io_wdata;
                    log_wr[n_log] <= io_wr;
                    log_sel[n_log] <= sel_lo;
                    n_log <= n_log + 1;
                    // opcode accepted: ask for the operands it needs
                    if (!sel_lo && io_wr) begin
                        ops_left_ff <= ops;
                    end
                end
            end
        end
    end
endmodule : ncp_cop_model

// file: sim/ncp_port_tb_top.sv
/*
 * bench of the coprocessor port against its partner model.
 * assumes: design and model compiled first; sys_clk at 25 mhz.
 */
`timescale 1ns/1ps
`include "ncp_cfg.svh"
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin errors++; \
    $display("BAD %s expected %h seen %h", nm, exp, got); end end
module ncp_port_tb_top;
    // ------------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------------
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic cop_start = 1'b0;
    logic [15:0] cop_opcode = 16'h0;
    logic cop_has_operand = 1'b0, cop_dword = 1'b0, cop_rd = 1'b0;
    logic [31:0] cop_operand = 32'h0;
    logic wait_start = 1'b0, nmi_pending = 1'b0, irq_pending = 1'b0;
    logic core_stall, cop_done, fault_pulse, wait_broken, selftest_req;
    logic [31:0] cop_rdata;
    logic [7:0] fault_vector;
    logic busy_n, error_n, operand_xfer_request, io_req, io_wr, io_ack;
    logic [23:0] io_addr;
    logic [15:0] io_wdata, io_rdata;
    logic busy_on = 1'b0, err_on = 1'b0, selftest = 1'b0; // partner controls
    logic [1:0] ack_dly = 2'h0, ops = 2'h0;
    int errors = 0, checked = 0;
    logic [2:0] got, exp; // end pulses seen, wanted
    int base, hold; // log mark, cycle count
    always #20 sys_clk = ~sys_clk;

    ncp_port ncp_port_inst (
        .sys_clk, .nrst, .clk_en(1'b1), .cop_start, .cop_opcode, .cop_has_operand, .cop_dword,
        .cop_rd, .cop_operand, .wait_start, .nmi_pending, .irq_pending, .core_stall, .cop_done,
        .cop_rdata, .fault_pulse, .fault_vector, .wait_broken, .selftest_req, .busy_n, .error_n,
        .operand_xfer_request, .io_req, .io_addr, .io_wr, .io_wdata, .io_rdata, .io_ack);
    ncp_cop_model ncp_cop_model_inst (
        .sys_clk, .nrst, .busy_on, .err_on, .selftest, .ack_dly, .ops, .busy_n, .error_n,
        .operand_xfer_request, .io_req, .io_addr, .io_wr, .io_wdata, .io_rdata, .io_ack);

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done

    // reset with the strap level on busy, held 16 cycles
    task automatic do_reset(input logic st);
        selftest = st;
        nrst = 1'b0;
        repeat (16) @(negedge sys_clk);
        nrst = 1'b1;
        repeat (6) @(negedge sys_clk);
        `CHK("selftest", st, selftest_req)
        selftest = 1'b0;
        repeat (6) @(negedge sys_clk);
        $display("test reset ended");
    endtask : do_reset

    // pulses land one cycle only, so look at every falling edge
    task automatic wait_end(output logic [2:0] got);
        got = 3'b000;
        for (int i = 0; i < 300 && got === 3'b000; i++) begin
            @(negedge sys_clk);
            got = {wait_broken, fault_pulse, cop_done};
        end
        if (got === 3'b000) begin
            errors++;
            test_done();
        end
    endtask : wait_end

    task automatic launch(input logic [15:0] opc, input logic ho, dw, rd, input logic [31:0] opd);
        base = ncp_cop_model_inst.n_log;
        cop_opcode = opc;
        cop_has_operand = ho;
        cop_dword = dw;
        cop_rd = rd;
        cop_operand = opd;
        cop_start = 1'b1;
        @(negedge sys_clk);
        cop_start = 1'b0;
    endtask : launch

    task automatic chk_entry(input int i, input logic [23:0] a, input logic w, logic [15:0] d);
        `CHK("address", a, ncp_cop_model_inst.log_addr[i])
        `CHK("direction", w, ncp_cop_model_inst.log_wr[i])
        if (w) `CHK("wdata", d, ncp_cop_model_inst.log_dat[i])
        `CHK("select", a[2], ncp_cop_model_inst.log_sel[i])
        `CHK("above pio", 1'b1, ncp_cop_model_inst.log_addr[i] > `NCP_PIO_TOP)
    endtask : chk_entry

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    // opcode goes out at once, with no handshake cycle before it
    task automatic t_opcode();
        ack_dly = 2'h0;
        launch(16'hd9e8, 1'b0, 1'b0, 1'b0, 32'h0);
        for (hold = 1; io_req !== 1'b1 && hold < 20; hold++) begin
            @(negedge sys_clk);
        end
        `CHK("opcode delay", 1'b1, hold <= 5)
        wait_end(got);
        `CHK("opcode end", 3'b001, got)
        `CHK("opcode cycles", base + 1, ncp_cop_model_inst.n_log)
        chk_entry(base, `NCP_ADDR_OPCODE, 1'b1, 16'hd9e8);
        $display("test opcode ended");
    endtask : t_opcode

    // a busy partner holds the opcode back until it frees up
    task automatic t_gate();
        ack_dly = 2'h1;
        busy_on = 1'b1;
        repeat (4) @(negedge sys_clk);
        launch(16'hd9c9, 1'b0, 1'b0, 1'b0, 32'h0);
        hold = 0;
        for (int i = 0; i < 12; i++) begin
            @(negedge sys_clk);
            if (io_req !== 1'b0 || core_stall !== 1'b1) hold++;
        end
        `CHK("gated", 0, hold)
        busy_on = 1'b0;
        wait_end(got);
        `CHK("gate end", 3'b001, got)
        `CHK("gate cycles", base + 1, ncp_cop_model_inst.n_log)
        $display("test gate ended");
    endtask : t_gate

    // error seen at the check: fault, and no bus cycle at all
    task automatic t_fault();
        err_on = 1'b1;
        repeat (4) @(negedge sys_clk);
        launch(16'hd9ee, 1'b0, 1'b0, 1'b0, 32'h0);
        wait_end(got);
        `CHK("fault end", 3'b010, got)
        `CHK("fault vector", `NCP_FAULT_VEC, fault_vector)
        `CHK("fault cycles", base, ncp_cop_model_inst.n_log)
        err_on = 1'b0;
        repeat (4) @(negedge sys_clk);
        $display("test fault ended");
    endtask : t_fault

    // operand served on demand; a doubleword goes low half then high half
    task automatic t_operand(input logic dw, input logic rd, input logic [1:0] dly);
        ack_dly = dly;
        ops = 2'h1;
        launch(16'hd8c1, 1'b1, dw, rd, 32'h1234abcd);
        wait_end(got);
        ops = 2'h0;
        `CHK("operand end", 3'b001, got)
        `CHK("operand cycles", base + 2 + dw, ncp_cop_model_inst.n_log)
        chk_entry(base, `NCP_ADDR_OPCODE, 1'b1, 16'hd8c1);
        chk_entry(base + 1, `NCP_ADDR_OPERAND, !rd, 16'habcd);
        if (dw) chk_entry(base + 2, `NCP_ADDR_OPERAND_HI, !rd, 16'h1234);
        if (rd) `CHK("rdata low", 16'ha5fc, cop_rdata[15:0])
        if (rd && dw) `CHK("rdata high", 16'ha5fe, cop_rdata[31:16])
        $display("test operand ended");
    endtask : t_operand

    // wait: 0 release, 1 release with error, 2 irq, 3 nmi, 4 error while idle
    task automatic t_wait(input int m);
        exp = (m == 2 || m == 3) ? 3'b100 : (m == 1 || m == 4) ? 3'b010 : 3'b001;
        busy_on = (m != 4);
        err_on = (m == 4);
        repeat (4) @(negedge sys_clk);
        wait_start = 1'b1;
        @(negedge sys_clk);
        wait_start = 1'b0;
        hold = 0;
        for (int i = 0; i < 8 && m != 4; i++) begin
            @(negedge sys_clk);
            if (core_stall !== 1'b1 || {cop_done, fault_pulse, wait_broken} !== 3'b000) hold++;
        end
        `CHK("wait stall", 0, hold)
        busy_on = busy_on && m > 1;
        err_on = err_on || m == 1;
        irq_pending = (m == 2);
        nmi_pending = (m == 3);
        wait_end(got);
        `CHK("wait end", exp, got)
        if (exp == 3'b010) `CHK("wait vector", `NCP_FAULT_VEC, fault_vector)
        irq_pending = 1'b0;
        nmi_pending = 1'b0;
        busy_on = 1'b0;
        err_on = 1'b0;
        repeat (4) @(negedge sys_clk);
        $display("test wait mode %0d ended", m);
    endtask : t_wait

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        do_reset(1'b1);
        do_reset(1'b0);
        t_opcode();
        t_gate();
        t_fault();
        t_operand(1'b1, 1'b0, 2'h2);
        t_operand(1'b0, 1'b1, 2'h3);
        t_operand(1'b1, 1'b1, 2'h2);
        for (int m = 0; m < 5; m++) begin
            t_wait(m);
        end
        test_done();
    end
endmodule : ncp_port_tb_top
